// ==== vector_packet_formatter.sv ====
// How it works
// - Numeric vector types encode as 011 standard, 100 special format, 111 numbered.
// - Secure, alphanumeric and hex/binary vectors encode as 000, 101 and 110.
// - Each vector packet carries the seven-bit vector word position, legal from 2 to 87.
// - Error flag set on over two bit errors, failed check character or invalid value.
// - Two-bit phase field gives the receive phase, 0 to 3 for a to d.
// - Numeric packets carry the message's initial check bits in a four-bit field.
// - Numeric length field holds word count minus one.
// - For long addresses the first message word follows the vector word directly.
// - Numeric start field gives message start word 3 to 87, second word if long.
// - Non-numeric packets use seven length bits split over bytes 1 and 0.
// - Non-numeric length counts message words in the frame, 1 to 85.
// - Non-numeric start field 3 to 87; long addresses point at the second word.
// - Numeric packets put check bits and upper length bits in byte 1.
// - Message words of an errored vector are never sent.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module vector_packet_formatter #(
  parameter int CNT_W = 16 // Width of each packet counter.
) (
  input wire logic core_clk_in, // Decoder clock, 20 MHz.
  input wire logic rst_in, // Asynchronous reset, active high.
  input wire logic awvalid_in, // AXI write address valid.
  output logic awready_out, // AXI write address ready.
  input wire logic [7:0] awaddr_in, // AXI write address.
  input wire logic wvalid_in, // AXI write data valid.
  output logic wready_out, // AXI write data ready.
  input wire logic [31:0] wdata_in, // AXI write data.
  input wire logic [3:0] wstrb_in, // AXI write byte strobes.
  output logic bvalid_out, // AXI write response valid.
  input wire logic bready_in, // AXI write response ready.
  output logic [1:0] bresp_out, // AXI write response code.
  input wire logic arvalid_in, // AXI read address valid.
  output logic arready_out, // AXI read address ready.
  input wire logic [7:0] araddr_in, // AXI read address.
  output logic rvalid_out, // AXI read data valid.
  input wire logic rready_in, // AXI read data ready.
  output logic [31:0] rdata_out, // AXI read data.
  output logic [1:0] rresp_out, // AXI read response code.
  input wire logic vec_valid_in, // Decoded vector offered.
  input wire vec_pkt_pkg::vector_desc_s vec_in, // Decoded vector.
  output logic vec_ready_out, // Vector taken when valid and ready.
  input wire logic msg_valid_in, // Message word offered.
  input wire vec_pkt_pkg::msg_word_s msg_in, // Message word.
  output logic msg_ready_out, // Message word taken when valid and ready.
  output logic pkt_valid_out, // Packet to the serial interface valid.
  output logic [31:0] pkt_data_out, // Packet bytes 3..0.
  input wire logic pkt_ready_in, // Serial interface takes the packet.
  output logic irq_out // Level interrupt.
);

  typedef enum logic [1:0] {WIN_IDLE, WIN_LONG_FIRST, WIN_RANGE} window_e;

  window_e win_state;
  logic [1:0] ctrl;
  logic [3:0] irq_status;
  logic [3:0] irq_enable;
  logic [CNT_W-1:0] vec_count;
  logic [CNT_W-1:0] err_count;
  logic [31:0] last_pkt;
  logic [6:0] win_vec_pos;
  logic [1:0] win_phase;
  logic [6:0] win_start;
  logic [6:0] win_left;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic vec_err;
  logic vec_numeric;
  logic [31:0] vec_pkt;
  logic vec_take;
  logic msg_take;
  logic msg_match;
  logic msg_in_range;
  logic next_pkt_valid;
  logic can_take;
  logic do_write;
  logic [3:0] irq_events;
  logic [3:0] irq_clear;

  // Error checking of the offered vector.
  vector_validator u_validator (
    .desc_in(vec_in),
    .err_out(vec_err),
    .numeric_out(vec_numeric)
  );

  // Byte layout of the vector packet.
  packet_assembler u_assembler (
    .desc_in(vec_in),
    .err_in(vec_err),
    .numeric_in(vec_numeric),
    .pkt_out(vec_pkt)
  );

  // Register address decode.
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
    reg_hit = (addr == offset);
  endfunction : reg_hit

  function automatic logic reg_mapped(input logic [7:0] addr);
    reg_mapped = addr inside {vec_pkt_pkg::REG_CTRL, vec_pkt_pkg::REG_STATUS, vec_pkt_pkg::REG_IRQ_STATUS,
                              vec_pkt_pkg::REG_IRQ_CLEAR, vec_pkt_pkg::REG_IRQ_ENABLE, vec_pkt_pkg::REG_COUNTS,
                              vec_pkt_pkg::REG_LAST_PKT};
  endfunction : reg_mapped

  // Handshakes of the data path and the message window check.
  always_comb begin
    vec_take = vec_valid_in && vec_ready_out;
    msg_take = msg_valid_in && msg_ready_out;
    msg_in_range = (msg_in.word_position >= win_start) &&
                   ({1'b0, msg_in.word_position} < ({1'b0, win_start} + {1'b0, win_left}));
    msg_match = 1'b0;
    if (msg_in.phase == win_phase) begin
      unique case (win_state)
        WIN_IDLE: msg_match = 1'b0;
        WIN_LONG_FIRST: msg_match = (msg_in.word_position == win_vec_pos + 7'h01);
        WIN_RANGE: msg_match = msg_in_range;
      endcase
    end
    if (!ctrl[vec_pkt_pkg::CTRL_FILTER_BIT]) begin
      msg_match = 1'b1;
    end
    next_pkt_valid = pkt_valid_out && !pkt_ready_in;
    if (vec_take || (msg_take && msg_match)) begin
      next_pkt_valid = 1'b1;
    end
    can_take = !next_pkt_valid && ctrl[vec_pkt_pkg::CTRL_ENABLE_BIT] && !(vec_take || msg_take);
  end

  // Packet register, loaded by a vector or a matching word.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pkt_valid_out <= 1'b0;
      pkt_data_out <= 32'h0;
    end else begin
      pkt_valid_out <= next_pkt_valid;
      if (vec_take) begin
        pkt_data_out <= vec_pkt;
      end else if (msg_take && msg_match) begin
        pkt_data_out <= {1'b0, msg_in.word_position, msg_in.data};
      end
    end
  end

  // Both readies can rise together; message ready drops the cycle after a vector is offered, and a word taken with a vector loses the packet register to it.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      vec_ready_out <= 1'b0;
      msg_ready_out <= 1'b0;
    end else begin
      vec_ready_out <= can_take;
      msg_ready_out <= can_take && !vec_valid_in;
    end
  end

  // Message window opened by each error-free vector.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      win_state <= WIN_IDLE;
      win_vec_pos <= 7'h0;
      win_phase <= 2'h0;
      win_start <= 7'h0;
      win_left <= 7'h0;
    end else if (vec_take) begin
      win_vec_pos <= vec_in.vector_word_position;
      win_phase <= vec_in.phase;
      win_start <= vec_in.msg_start;
      if (vec_err) begin
        win_state <= WIN_IDLE;
        win_left <= 7'h0;
      end else if (vec_in.long_addr) begin
        win_state <= WIN_LONG_FIRST;
        win_left <= vec_in.msg_len - 7'h01;
      end else begin
        win_state <= WIN_RANGE;
        win_left <= vec_in.msg_len;
      end
    end else if (msg_take && msg_match && ctrl[vec_pkt_pkg::CTRL_FILTER_BIT]) begin
      unique case (win_state)
        WIN_LONG_FIRST: win_state <= (win_left == 7'h0) ? WIN_IDLE : WIN_RANGE;
        WIN_RANGE: win_state <= (msg_in.word_position == win_start + win_left - 7'h01) ? WIN_IDLE : WIN_RANGE;
        WIN_IDLE: win_state <= WIN_IDLE;
      endcase
    end
  end

  // Event counters and the copy of the last vector packet.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      vec_count <= '0;
      err_count <= '0;
      last_pkt <= 32'h0;
    end else if (vec_take) begin
      vec_count <= vec_count + 1'b1;
      last_pkt <= vec_pkt;
      if (vec_err) begin
        err_count <= err_count + 1'b1;
      end
    end
  end

  // Write address and data latch in either order.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      awready_out <= 1'b1;
      aw_held <= 1'b0;
      aw_addr <= 8'h0;
    end else if (awvalid_in && awready_out) begin
      awready_out <= 1'b0;
      aw_held <= 1'b1;
      aw_addr <= awaddr_in;
    end else if (do_write) begin
      awready_out <= 1'b1;
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wready_out <= 1'b1;
      w_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else if (wvalid_in && wready_out) begin
      wready_out <= 1'b0;
      w_held <= 1'b1;
      w_data <= wdata_in;
      w_strb <= wstrb_in;
    end else if (do_write) begin
      wready_out <= 1'b1;
      w_held <= 1'b0;
    end
  end

  assign do_write = aw_held && w_held && !bvalid_out;

  // Write response; unmapped addresses answer with a slave error.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bvalid_out <= 1'b0;
      bresp_out <= vec_pkt_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_out <= 1'b1;
      bresp_out <= reg_mapped(aw_addr) ? vec_pkt_pkg::RESP_OKAY : vec_pkt_pkg::RESP_SLVERR;
    end else if (bready_in) begin
      bvalid_out <= 1'b0;
    end
  end

  // Writable control and interrupt enable registers, low byte lane only.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl <= vec_pkt_pkg::CTRL_RESET;
      irq_enable <= vec_pkt_pkg::IRQ_ENABLE_RESET;
    end else if (do_write && w_strb[0]) begin
      if (reg_hit(aw_addr, vec_pkt_pkg::REG_CTRL)) begin
        ctrl <= w_data[1:0];
      end
      if (reg_hit(aw_addr, vec_pkt_pkg::REG_IRQ_ENABLE)) begin
        irq_enable <= w_data[3:0];
      end
    end
  end

  // Interrupt events and write-one-to-clear pulses.
  always_comb begin
    irq_events = 4'h0;
    irq_events[vec_pkt_pkg::IRQ_VEC_SENT] = vec_take;
    irq_events[vec_pkt_pkg::IRQ_VEC_ERROR] = vec_take && vec_err;
    irq_events[vec_pkt_pkg::IRQ_MSG_DROPPED] = msg_take && !msg_match;
    irq_events[vec_pkt_pkg::IRQ_MSG_SENT] = msg_take && msg_match;
    irq_clear = 4'h0;
    if (do_write && w_strb[0] && reg_hit(aw_addr, vec_pkt_pkg::REG_IRQ_CLEAR)) begin
      irq_clear = w_data[3:0];
    end
  end

  // Sticky status: a new event wins over a clear in the same cycle.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_status <= 4'h0;
      irq_out <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_events;
      irq_out <= |(((irq_status & ~irq_clear) | irq_events) & irq_enable);
    end
  end

  // Read channel: data is captured at the address handshake.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      arready_out <= 1'b1;
      rvalid_out <= 1'b0;
      rdata_out <= 32'h0;
      rresp_out <= vec_pkt_pkg::RESP_OKAY;
    end else if (arvalid_in && arready_out) begin
      arready_out <= 1'b0;
      rvalid_out <= 1'b1;
      rresp_out <= reg_mapped(araddr_in) ? vec_pkt_pkg::RESP_OKAY : vec_pkt_pkg::RESP_SLVERR;
      unique case (araddr_in)
        vec_pkt_pkg::REG_CTRL: rdata_out <= {30'h0, ctrl};
        vec_pkt_pkg::REG_STATUS: rdata_out <= {14'h0, win_phase, win_left, win_start, win_state};
        vec_pkt_pkg::REG_IRQ_STATUS: rdata_out <= {28'h0, irq_status};
        vec_pkt_pkg::REG_IRQ_ENABLE: rdata_out <= {28'h0, irq_enable};
        vec_pkt_pkg::REG_COUNTS: rdata_out <= {err_count[15:0], vec_count[15:0]};
        vec_pkt_pkg::REG_LAST_PKT: rdata_out <= last_pkt;
        default: rdata_out <= 32'h0;
      endcase
    end else if (rvalid_out && rready_in) begin
      rvalid_out <= 1'b0;
      arready_out <= 1'b1;
    end
  end

endmodule : vector_packet_formatter
`default_nettype wire

// ==== vec_pkt_pkg.sv ====
package vec_pkt_pkg;

  // Three-bit vector type codes carried in the packet.
  localparam logic [2:0] VT_SECURE = 3'h0;
  localparam logic [2:0] VT_STD_NUMERIC = 3'h3;
  localparam logic [2:0] VT_SPECIAL_NUMERIC = 3'h4;
  localparam logic [2:0] VT_ALPHANUMERIC = 3'h5;
  localparam logic [2:0] VT_HEX_BINARY = 3'h6;
  localparam logic [2:0] VT_NUMBERED_NUMERIC = 3'h7;

  // Legal ranges of the vector fields.
  localparam logic [6:0] WORD_POS_MIN = 7'h02;
  localparam logic [6:0] WORD_POS_MAX = 7'h57;
  localparam logic [6:0] START_MIN = 7'h03;
  localparam logic [6:0] START_MAX = 7'h57;
  localparam logic [6:0] LEN_MIN = 7'h01;
  localparam logic [6:0] NUM_LEN_MAX = 7'h08;
  localparam logic [6:0] MSG_LEN_MAX = 7'h55;
  localparam logic [2:0] MAX_CORRECTED_BITS = 3'h2;

  // Bit positions inside the 32-bit vector packet (byte 3 in bits 31:24).
  localparam int POS_WORD_POS = 24;
  localparam int POS_ERR = 23;
  localparam int POS_PHASE = 21;
  localparam int POS_VTYPE = 16;
  localparam int POS_CHECK = 10;
  localparam int POS_LEN = 7;
  localparam int POS_START = 0;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_CLEAR = 8'h0C;
  localparam logic [7:0] REG_IRQ_ENABLE = 8'h10;
  localparam logic [7:0] REG_COUNTS = 8'h14;
  localparam logic [7:0] REG_LAST_PKT = 8'h18;

  // Reset values and field layout of the registers.
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_FILTER_BIT = 1;
  localparam logic [3:0] IRQ_ENABLE_RESET = 4'h0;
  localparam int IRQ_VEC_SENT = 0;
  localparam int IRQ_VEC_ERROR = 1;
  localparam int IRQ_MSG_DROPPED = 2;
  localparam int IRQ_MSG_SENT = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // One decoded vector word as delivered by the frame decoder.
  typedef struct packed {
    logic [6:0] vector_word_position;
    logic [1:0] phase;
    logic [2:0] vtype;
    logic [2:0] bit_errors;
    logic check_fail;
    logic value_bad;
    logic long_addr;
    logic [3:0] check_bits;
    logic [6:0] msg_len;
    logic [6:0] msg_start;
  } vector_desc_s;

  // One message word with its frame position and phase.
  typedef struct packed {
    logic [6:0] word_position;
    logic [1:0] phase;
    logic [23:0] data;
  } msg_word_s;

endpackage : vec_pkt_pkg

// ==== vector_validator.sv ====
`timescale 1ns/100ps
`default_nettype none
module vector_validator (
  input wire vec_pkt_pkg::vector_desc_s desc_in, // Vector under test.
  output logic err_out, // Error flag for the packet.
  output logic numeric_out // Vector is one of the numeric kinds.
);

  logic type_ok;
  logic len_ok;
  logic start_ok;
  logic pos_ok;

  // Classify the type code and check every field range.
  always_comb begin
    numeric_out = (desc_in.vtype == vec_pkt_pkg::VT_STD_NUMERIC) ||
                  (desc_in.vtype == vec_pkt_pkg::VT_SPECIAL_NUMERIC) ||
                  (desc_in.vtype == vec_pkt_pkg::VT_NUMBERED_NUMERIC);
    type_ok = numeric_out || (desc_in.vtype == vec_pkt_pkg::VT_SECURE) ||
              (desc_in.vtype == vec_pkt_pkg::VT_ALPHANUMERIC) ||
              (desc_in.vtype == vec_pkt_pkg::VT_HEX_BINARY);
    len_ok = (desc_in.msg_len >= vec_pkt_pkg::LEN_MIN) &&
             (desc_in.msg_len <= (numeric_out ? vec_pkt_pkg::NUM_LEN_MAX : vec_pkt_pkg::MSG_LEN_MAX));
    start_ok = (desc_in.msg_start >= vec_pkt_pkg::START_MIN) &&
               (desc_in.msg_start <= vec_pkt_pkg::START_MAX);
    pos_ok = (desc_in.vector_word_position >= vec_pkt_pkg::WORD_POS_MIN) &&
             (desc_in.vector_word_position <= vec_pkt_pkg::WORD_POS_MAX);
    err_out = (desc_in.bit_errors > vec_pkt_pkg::MAX_CORRECTED_BITS) || desc_in.check_fail ||
              desc_in.value_bad || !type_ok || !len_ok || !start_ok || !pos_ok;
  end

endmodule : vector_validator
`default_nettype wire

// ==== packet_assembler.sv ====
`timescale 1ns/100ps
`default_nettype none
module packet_assembler (
  input wire vec_pkt_pkg::vector_desc_s desc_in, // Vector to format.
  input wire logic err_in, // Error flag to place.
  input wire logic numeric_in, // Numeric layout selected.
  output logic [31:0] pkt_out // Four-byte packet, byte 3 on top.
);

  logic [6:0] len_minus_one;

  // Lay the fields out; unused bits are driven to zero.
  always_comb begin
    len_minus_one = desc_in.msg_len - 7'h01;
    pkt_out = 32'h0;
    pkt_out[vec_pkt_pkg::POS_WORD_POS +: 7] = desc_in.vector_word_position;
    pkt_out[vec_pkt_pkg::POS_ERR] = err_in;
    pkt_out[vec_pkt_pkg::POS_PHASE +: 2] = desc_in.phase;
    pkt_out[vec_pkt_pkg::POS_VTYPE +: 3] = desc_in.vtype;
    pkt_out[vec_pkt_pkg::POS_START +: 7] = desc_in.msg_start;
    if (numeric_in) begin
      pkt_out[vec_pkt_pkg::POS_CHECK +: 4] = desc_in.check_bits;
      pkt_out[vec_pkt_pkg::POS_LEN +: 3] = len_minus_one[2:0];
    end else begin
      pkt_out[vec_pkt_pkg::POS_LEN +: 7] = desc_in.msg_len;
    end
  end

endmodule : packet_assembler
`default_nettype wire

// ==== vector_packet_formatter_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module vector_packet_formatter_checker (
  input wire logic core_clk_in, // Decoder clock.
  input wire logic rst_in, // Asynchronous reset.
  input wire logic vec_valid_in, // Vector offered.
  input wire vec_pkt_pkg::vector_desc_s vec_in, // Decoded vector.
  input wire logic vec_ready_out, // Vector taken.
  input wire logic msg_valid_in, // Message word offered.
  input wire logic msg_ready_out, // Message word taken.
  input wire logic pkt_valid_out, // Packet valid.
  input wire logic [31:0] pkt_data_out, // Packet bytes.
  input wire logic pkt_ready_in, // Packet read.
  input wire logic irq_out // Interrupt.
);
  logic vtake;
  logic numeric;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // A vector handshake, and whether it uses the numeric layout.
  assign vtake = vec_valid_in && vec_ready_out;
  assign numeric = vec_in.vtype inside {3'h3, 3'h4, 3'h7};
  a_vec_answer: assert property (vtake |=> pkt_valid_out && !pkt_data_out[31])
    else $error("no packet");
  a_word_pos: assert property (vtake |=> pkt_data_out[30:24] == $past(vec_in.vector_word_position))
    else $error("bad position");
  a_phase_field: assert property (vtake |=> pkt_data_out[22:21] == $past(vec_in.phase))
    else $error("bad phase");
  a_type_code: assert property (vtake |=> pkt_data_out[18:16] == $past(vec_in.vtype))
    else $error("bad type");
  a_err_bits: assert property (vtake && vec_in.bit_errors > 3'h2 |=> pkt_data_out[23])
    else $error("no error flag");
  a_num_fields: assert property (vtake && numeric && vec_in.msg_len inside {[7'h01:7'h08]} |=>
    pkt_data_out[13:7] == {$past(vec_in.check_bits), $past(vec_in.msg_len[2:0]) - 3'h1})
    else $error("bad numeric fields");
  a_text_len: assert property (vtake && !numeric |=> pkt_data_out[15:7] == {2'h0, $past(vec_in.msg_len)})
    else $error("bad length");
  a_start_field: assert property (vtake |=> pkt_data_out[6:0] == $past(vec_in.msg_start))
    else $error("bad start");
  a_unused_zero: assert property (vtake |=> pkt_data_out[20:19] == 2'h0 && pkt_data_out[15:14] == 2'h0)
    else $error("unused bits set");
  a_pkt_hold: assert property (pkt_valid_out && !pkt_ready_in |=> pkt_valid_out && $stable(pkt_data_out))
    else $error("packet not held");
  c_numeric: cover property (vtake && numeric);
  c_error: cover property (vtake && vec_in.check_fail);
  c_message: cover property (msg_valid_in && msg_ready_out);
  c_irq: cover property ($rose(irq_out));
endmodule : vector_packet_formatter_checker
`default_nettype wire

// ==== pkt_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module pkt_host_model (
  input wire logic core_clk_in, // Clock.
  input wire logic rst_in, // Reset.
  input wire logic slow_in, // Idle a while after each packet.
  input wire logic pkt_valid_in, // Packet offered.
  input wire logic [31:0] pkt_data_in, // Packet bytes.
  output logic pkt_ready_out, // Packet read.
  output logic [31:0] last_out, // Last packet read.
  output logic [7:0] count_out // Packets read.
);
  logic [1:0] idle;
  // Takes a packet, then idles three cycles if slow.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pkt_ready_out <= 1'b0;
      last_out <= 32'h0;
      count_out <= 8'h0;
      idle <= 2'h0;
    end else if (pkt_valid_in && pkt_ready_out) begin
      last_out <= pkt_data_in;
      count_out <= count_out + 8'h1;
      pkt_ready_out <= 1'b0;
      idle <= slow_in ? 2'h3 : 2'h0;
    end else if (idle != 2'h0) begin
      idle <= idle - 2'h1;
    end else begin
      pkt_ready_out <= 1'b1;
    end
  end
endmodule : pkt_host_model
`default_nettype wire

// ==== tb_paging_vector_packet_formatter.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_paging_vector_packet_formatter;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready, vec_valid, msg_valid, slow;
  logic awready, wready, bvalid, arready, rvalid, vec_ready, msg_ready, pkt_valid, pkt_ready, irq;
  logic [7:0] awaddr, araddr, hcnt;
  logic [31:0] wdata, rdata, pkt_data, hlast, last_vec;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  vec_pkt_pkg::vector_desc_s vec;
  vec_pkt_pkg::msg_word_s msg;
  int miscompares, compares;
  // Block under test and the host reading its packets.
  vector_packet_formatter vector_packet_formatter_inst (.core_clk_in(clk), .rst_in(rst),
    .awvalid_in(awvalid), .awready_out(awready), .awaddr_in(awaddr), .wvalid_in(wvalid),
    .wready_out(wready), .wdata_in(wdata), .wstrb_in(wstrb), .bvalid_out(bvalid), .bready_in(bready),
    .bresp_out(bresp), .arvalid_in(arvalid), .arready_out(arready), .araddr_in(araddr),
    .rvalid_out(rvalid), .rready_in(rready), .rdata_out(rdata), .rresp_out(rresp),
    .vec_valid_in(vec_valid), .vec_in(vec), .vec_ready_out(vec_ready), .msg_valid_in(msg_valid),
    .msg_in(msg), .msg_ready_out(msg_ready), .pkt_valid_out(pkt_valid), .pkt_data_out(pkt_data),
    .pkt_ready_in(pkt_ready), .irq_out(irq));
  pkt_host_model pkt_host_model_inst (.core_clk_in(clk), .rst_in(rst), .slow_in(slow),
    .pkt_valid_in(pkt_valid), .pkt_data_in(pkt_data), .pkt_ready_out(pkt_ready),
    .last_out(hlast), .count_out(hcnt));
  // Free-running 20 MHz clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // Polls at falling edges.
  task automatic wait_hi(input int sel);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > 200) begin
        check("handshake timeout", 32'h1, 32'h0);
        end_of_test();
      end
    end while (!(sel == 0 ? awready && wready : sel == 1 ? bvalid : sel == 2 ? arready :
      sel == 3 ? rvalid : sel == 4 ? vec_ready : msg_ready));
  endtask : wait_hi
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    wait_hi(0);
    @(posedge clk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    wait_hi(1);
    r = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    wait_hi(2);
    @(posedge clk);
    arvalid <= 1'b0;
    wait_hi(3);
    d = rdata;
    r = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask : axi_rd
  task automatic offer(input logic v, input vec_pkt_pkg::vector_desc_s d, input vec_pkt_pkg::msg_word_s m);
    @(posedge clk);
    vec_valid <= v;
    msg_valid <= !v;
    vec <= d;
    msg <= m;
    wait_hi(v ? 4 : 5);
    @(posedge clk);
    vec_valid <= 1'b0;
    msg_valid <= 1'b0;
  endtask : offer
  task automatic get_pkt(input logic [7:0] c0, output logic [31:0] p);
    int n;
    n = 0;
    while (hcnt == c0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (hcnt == c0) begin
      check("packet timeout", 32'h1, 32'h0);
      end_of_test();
    end
    p = hlast;
  endtask : get_pkt
  function automatic vec_pkt_pkg::vector_desc_s mk(input logic [6:0] p, input logic [2:0] t,
    input logic [6:0] n, input logic [6:0] s);
    mk = '0;
    mk.vector_word_position = p;
    mk.phase = p[1:0];
    mk.vtype = t;
    mk.check_bits = 4'hA;
    mk.msg_len = n;
    mk.msg_start = s;
  endfunction : mk
  function automatic logic [31:0] exp_pkt(input vec_pkt_pkg::vector_desc_s d, input logic e);
    logic [6:0] n;
    n = d.vtype inside {3'h3, 3'h4, 3'h7} ? {d.check_bits, d.msg_len[2:0] - 3'h1} : d.msg_len;
    return {1'b0, d.vector_word_position, e, d.phase, 5'(d.vtype), 2'h0, n, d.msg_start};
  endfunction : exp_pkt
  task automatic vec_case(input vec_pkt_pkg::vector_desc_s d, input logic e);
    logic [7:0] c0;
    c0 = hcnt;
    offer(1'b1, d, '0);
    get_pkt(c0, last_vec);
    check("vector packet", last_vec, exp_pkt(d, e));
  endtask : vec_case
  task automatic msg_case(input logic [6:0] p, input logic [1:0] ph, input logic pass);
    logic [7:0] c0;
    logic [31:0] q;
    c0 = hcnt;
    offer(1'b0, '0, {p, ph, 24'hA5A5A5});
    if (pass) begin
      get_pkt(c0, q);
      check("message packet", q, {1'b0, p, 24'hA5A5A5});
    end else begin
      repeat (4) @(negedge clk);
      check("dropped word", {24'h0, hcnt}, {24'h0, c0});
    end
  endtask : msg_case
  // All types at field limits, host fast and slow.
  task automatic t_types();
    logic [2:0] types [6] = '{3'h3, 3'h4, 3'h7, 3'h0, 3'h5, 3'h6};
    vec_pkt_pkg::vector_desc_s d;
    for (int i = 0; i < 6; i++) begin
      d = mk(i[0] ? 7'h57 : 7'h02 + 7'(i), types[i], i < 3 ? 7'h08 : 7'h55, i[0] ? 7'h03 : 7'h57);
      d.long_addr = i[0];
      slow <= i[1];
      vec_case(d, 1'b0);
    end
    slow <= 1'b0;
  endtask : t_types
  // Each error cause, then the corrected-bit limit.
  task automatic t_errors();
    vec_pkt_pkg::vector_desc_s d;
    for (int i = 0; i < 9; i++) begin
      d = mk(7'h10, 3'h5, 7'h02, 7'h20);
      case (i)
        0: d.bit_errors = 3'h3;
        1: d.check_fail = 1'b1;
        2: d.value_bad = 1'b1;
        3: d.msg_len = 7'h56;
        4: d.msg_start = 7'h02;
        5: d.vtype = 3'h1;
        6: d.vector_word_position = 7'h58;
        7: d = mk(7'h10, 3'h3, 7'h09, 7'h20);
        default: d.bit_errors = 3'h2;
      endcase
      vec_case(d, i != 8);
    end
  endtask : t_errors
  // Long-address message window, then an errored vector.
  task automatic t_msgs();
    vec_pkt_pkg::vector_desc_s d;
    d = mk(7'h14, 3'h5, 7'h03, 7'h1E);
    d.long_addr = 1'b1;
    vec_case(d, 1'b0);
    msg_case(7'h15, 2'h0, 1'b1);
    msg_case(7'h1E, 2'h1, 1'b0);
    msg_case(7'h1E, 2'h0, 1'b1);
    msg_case(7'h20, 2'h0, 1'b0);
    d.check_fail = 1'b1;
    vec_case(d, 1'b1);
    msg_case(7'h15, 2'h0, 1'b0);
  endtask : t_msgs
  // Registers: reset values, refusals, interrupts, enable.
  task automatic t_regs();
    logic [31:0] r;
    logic [1:0] s;
    axi_rd(8'h00, r, s);
    check("ctrl reset", r, 32'h3);
    axi_rd(8'h10, r, s);
    check("irq enable reset", r, 32'h0);
    axi_rd(8'h1C, r, s);
    check("unmapped read", {30'h0, s}, 32'h2);
    axi_wr(8'h1C, 32'h1, s);
    check("unmapped write", {30'h0, s}, 32'h2);
    axi_rd(8'h08, r, s);
    check("irq status", r, 32'hF);
    check("irq masked", {31'h0, irq}, 32'h0);
    axi_wr(8'h10, 32'h1, s);
    repeat (3) @(negedge clk);
    check("irq raised", {31'h0, irq}, 32'h1);
    axi_wr(8'h0C, 32'hF, s);
    repeat (3) @(negedge clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    axi_rd(8'h18, r, s);
    check("last packet", r, last_vec);
    axi_wr(8'h00, 32'h2, s);
    repeat (3) @(negedge clk);
    check("vector refused", {31'h0, vec_ready}, 32'h0);
    axi_wr(8'h00, 32'h3, s);
  endtask : t_regs
  // Reset, then the scenarios in turn.
  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready, vec_valid, msg_valid, slow} = 9'h100;
    {awaddr, araddr, wdata, vec, msg} = '0;
    wstrb = 4'hF;
    last_vec = 32'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_types();
    t_errors();
    t_msgs();
    t_regs();
    end_of_test();
  end
endmodule : tb_paging_vector_packet_formatter
bind vector_packet_formatter vector_packet_formatter_checker vector_packet_formatter_checker_inst (.*);
`default_nettype wire
